// ==== rtl/vpc_regs.sv ====
`timescale 1ns/1ns
module vpc_regs #(
    parameter logic [7:0] CHIP_VERSION = 8'h5a, // arbitrary value
    parameter logic [7:0] CHIP_REVISION = 8'h0c // arbitrary value
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // serial bus, data is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // straps and analog status
    input wire logic addr_select_i,
    input wire logic pll_locked_i,
    input wire logic phase_locked_i,
    // detector and feedback settings
    output logic detector_gate_mode_o,
    output logic detector_gate_polarity_o,
    output logic reference_edge_select_o,
    output logic feedback_edge_select_o,
    output logic feedback_source_select_o,
    output logic aux_sync_source_select_o,
    // working pll settings
    output logic [2:0] detector_gain_o,
    output logic [1:0] post_scaler_code_o,
    output logic [11:0] loop_divider_o,
    // phase adjuster settings
    output logic [5:0] phase_offset_value_o,
    output logic loop_filter_select_o,
    output logic [1:0] phase_step_resolution_o,
    // output drivers
    output logic [4:0] output_enable_o,
    output logic halfclk_invert_o,
    output logic [1:0] clk_scale_code_o,
    // reference oscillator
    output logic [6:0] osc_divider_modulus_o,
    output logic loop_input_select_o,
    // soft reset pulses and lock pin
    output logic pll_reset_o,
    output logic phase_reset_o,
    output logic lock_indicator_o
);
    vpc_line_if line (); // decoded bus events
    logic [2:0] level_s; // synced {addr select, phase lock, pll lock}
    logic pll_lock_s;
    logic phase_lock_s;
    logic addr_sel_s;

    vpc_pkg::vpc_state_type state_r; // serial engine state
    vpc_pkg::vpc_state_type after_ack_r; // state after our acknowledge
    logic [3:0] bit_cnt_r; // bits in the current byte
    logic [7:0] rx_shift_r; // received byte
    logic [7:0] tx_shift_r; // byte being sent
    logic [7:0] ptr_r; // register pointer
    logic sda_drive_r; // pull data low
    logic nack_r; // master declined more data
    logic byte_done; // eighth received bit complete
    logic addr_hit; // address byte is ours
    logic wr_en; // data byte written at ptr_r
    logic [7:0] read_byte; // register at ptr_r

    // holding and direct registers
    logic [7:0] input_ctrl_r;
    logic [7:0] loop_hold_r;
    logic [7:0] fdiv_low_hold_r;
    logic [7:0] fdiv_high_hold_r;
    logic [7:0] phase_ofs_r;
    logic [1:0] phase_res_hold_r;
    logic [7:0] out_en_r;
    logic [7:0] osc_div_r;
    // working copies
    logic [7:0] loop_work_r;
    logic [11:0] fdiv_work_r;
    logic [1:0] phase_res_work_r;
    // command decode
    logic cmd_wr;
    logic pll_load;
    logic phase_load;
    logic pll_reset_r;
    logic phase_reset_r;
    logic lock_ind_r;

    vpc_pins u_pins (
        .clk_sys_i (clk_sys_i),
        .reset_i (reset_i),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .line (line.phy)
    );

    vpc_level_sync u_level_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i (reset_i),
        .level_i ({addr_select_i, phase_locked_i, pll_locked_i}),
        .level_o (level_s)
    );

    assign pll_lock_s = level_s[0];
    assign phase_lock_s = level_s[1];
    assign addr_sel_s = level_s[2];

    // byte boundary and address match
    assign byte_done = line.scl_fall && (bit_cnt_r == vpc_pkg::BIT_CNT_DONE);
    assign addr_hit = rx_shift_r[7:1] == {vpc_pkg::DEV_ADDR_BASE, addr_sel_s};
    assign wr_en = (state_r == vpc_pkg::ST_WR) && byte_done;

    // serial engine; data changes only after a clock fall so setup holds
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= vpc_pkg::ST_IDLE;
            after_ack_r <= vpc_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            rx_shift_r <= 8'h00;
            tx_shift_r <= 8'h00;
            ptr_r <= 8'h00;
            sda_drive_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (line.start) begin
            // a start aborts anything, also a repeated start mid-read
            state_r <= vpc_pkg::ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_drive_r <= 1'b0;
        end else if (line.stop) begin
            state_r <= vpc_pkg::ST_IDLE;
            sda_drive_r <= 1'b0;
        end else begin
            case (state_r)
                vpc_pkg::ST_ADDR, vpc_pkg::ST_PTR, vpc_pkg::ST_WR: begin
                    if (line.scl_rise) begin
                        rx_shift_r <= {rx_shift_r[6:0], line.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt_r <= 4'h0;
                        sda_drive_r <= 1'b1;
                        state_r <= vpc_pkg::ST_ACK_OUT;
                        after_ack_r <= vpc_pkg::ST_WR;
                        if (state_r == vpc_pkg::ST_ADDR) begin
                            // foreign address: stay silent until next start
                            if (!addr_hit) begin
                                sda_drive_r <= 1'b0;
                                state_r <= vpc_pkg::ST_IDLE;
                            end else if (rx_shift_r[0]) begin
                                after_ack_r <= vpc_pkg::ST_RD;
                            end else begin
                                after_ack_r <= vpc_pkg::ST_PTR;
                            end
                        end else if (state_r == vpc_pkg::ST_PTR) begin
                            ptr_r <= rx_shift_r;
                        end else begin
                            // auto-increment for burst writes
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                vpc_pkg::ST_ACK_OUT: begin
                    if (line.scl_fall) begin
                        state_r <= after_ack_r;
                        bit_cnt_r <= 4'h0;
                        tx_shift_r <= read_byte;
                        sda_drive_r <= (after_ack_r == vpc_pkg::ST_RD) && !read_byte[7];
                    end
                end
                vpc_pkg::ST_RD: begin
                    if (line.scl_fall) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                        sda_drive_r <= !tx_shift_r[6];
                        if (bit_cnt_r == vpc_pkg::BIT_CNT_LAST) begin
                            // release the line for the master's answer
                            sda_drive_r <= 1'b0;
                            state_r <= vpc_pkg::ST_ACK_IN;
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                vpc_pkg::ST_ACK_IN: begin
                    if (line.scl_rise) begin
                        nack_r <= line.sda;
                    end
                    if (line.scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        tx_shift_r <= read_byte;
                        sda_drive_r <= !nack_r && !read_byte[7];
                        state_r <= nack_r ? vpc_pkg::ST_IDLE : vpc_pkg::ST_RD;
                    end
                end
                default: begin
                    state_r <= vpc_pkg::ST_IDLE;
                    sda_drive_r <= 1'b0;
                end
            endcase
        end
    end

    // read multiplexer; status is sampled live at load time
    always_comb begin
        case (ptr_r)
            vpc_pkg::OFF_INPUT_CTRL: read_byte = input_ctrl_r;
            vpc_pkg::OFF_LOOP_CTRL: read_byte = loop_hold_r;
            vpc_pkg::OFF_FDIV_LOW: read_byte = fdiv_low_hold_r;
            vpc_pkg::OFF_FDIV_HIGH: read_byte = fdiv_high_hold_r;
            vpc_pkg::OFF_PHASE_OFS: read_byte = phase_ofs_r;
            vpc_pkg::OFF_PHASE_CTRL: read_byte = {vpc_pkg::METAL_REV, phase_res_hold_r};
            vpc_pkg::OFF_OUT_EN: read_byte = out_en_r;
            vpc_pkg::OFF_OSC_DIV: read_byte = osc_div_r;
            vpc_pkg::OFF_CHIP_VER: read_byte = CHIP_VERSION;
            vpc_pkg::OFF_CHIP_REV: read_byte = CHIP_REVISION;
            vpc_pkg::OFF_LOCK_STAT: read_byte = {6'h00, pll_lock_s, phase_lock_s};
            default: read_byte = 8'h00; // command and unmapped read zero
        endcase
    end

    // host-visible registers; read-only offsets have no write path
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            input_ctrl_r <= vpc_pkg::RST_INPUT_CTRL;
            loop_hold_r <= vpc_pkg::RST_LOOP_CTRL;
            fdiv_low_hold_r <= vpc_pkg::RST_FDIV_LOW;
            fdiv_high_hold_r <= vpc_pkg::RST_FDIV_HIGH;
            phase_ofs_r <= vpc_pkg::RST_PHASE_OFS;
            phase_res_hold_r <= vpc_pkg::RST_PHASE_RES;
            out_en_r <= vpc_pkg::RST_OUT_EN;
            osc_div_r <= vpc_pkg::RST_OSC_DIV;
        end else if (wr_en) begin
            case (ptr_r)
                vpc_pkg::OFF_INPUT_CTRL: input_ctrl_r <= rx_shift_r;
                vpc_pkg::OFF_LOOP_CTRL: loop_hold_r <= rx_shift_r & vpc_pkg::MASK_LOOP_CTRL;
                vpc_pkg::OFF_FDIV_LOW: fdiv_low_hold_r <= rx_shift_r;
                vpc_pkg::OFF_FDIV_HIGH: fdiv_high_hold_r <= rx_shift_r & vpc_pkg::MASK_FDIV_HIGH;
                vpc_pkg::OFF_PHASE_OFS: phase_ofs_r <= rx_shift_r & vpc_pkg::MASK_PHASE_OFS;
                vpc_pkg::OFF_PHASE_CTRL: phase_res_hold_r <= rx_shift_r[1:0];
                vpc_pkg::OFF_OUT_EN: out_en_r <= rx_shift_r;
                vpc_pkg::OFF_OSC_DIV: osc_div_r <= rx_shift_r;
                default: begin
                    // read-only, command and unmapped offsets keep nothing
                end
            endcase
        end
    end

    // command register decode; both nibbles may act in one write
    assign cmd_wr = wr_en && (ptr_r == vpc_pkg::OFF_SOFT_RESET);
    assign pll_load = cmd_wr && (rx_shift_r[7:4] == vpc_pkg::CMD_PLL_NIBBLE);
    assign phase_load = cmd_wr && (rx_shift_r[3:0] == vpc_pkg::CMD_PHASE_NIBBLE);

    // working pll copy moves only on a pll command
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            loop_work_r <= vpc_pkg::RST_LOOP_CTRL;
            fdiv_work_r <= {vpc_pkg::RST_FDIV_HIGH[3:0], vpc_pkg::RST_FDIV_LOW};
        end else if (pll_load) begin
            loop_work_r <= loop_hold_r;
            fdiv_work_r <= {fdiv_high_hold_r[3:0], fdiv_low_hold_r};
        end
    end

    // working resolution moves only on a phase command
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            phase_res_work_r <= vpc_pkg::RST_PHASE_RES;
        end else if (phase_load) begin
            phase_res_work_r <= phase_res_hold_r;
        end
    end

    // one-cycle reset pulses to the analog blocks
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pll_reset_r <= 1'b0;
            phase_reset_r <= 1'b0;
        end else begin
            pll_reset_r <= pll_load;
            phase_reset_r <= phase_load;
        end
    end

    // lock pin; with both enables set the two conditions are ored
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lock_ind_r <= 1'b0;
        end else begin
            lock_ind_r <= (input_ctrl_r[vpc_pkg::IC_SHOW_LOOP] && pll_lock_s)
                || (input_ctrl_r[vpc_pkg::IC_SHOW_PHASE] && phase_lock_s);
        end
    end

    // outputs straight from flops, except sda_o which is tied low
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_drive_r;
    assign detector_gate_mode_o = input_ctrl_r[vpc_pkg::IC_GATE_MODE];
    assign detector_gate_polarity_o = input_ctrl_r[vpc_pkg::IC_GATE_POL];
    assign reference_edge_select_o = input_ctrl_r[vpc_pkg::IC_REF_EDGE];
    assign feedback_edge_select_o = input_ctrl_r[vpc_pkg::IC_FB_EDGE];
    assign feedback_source_select_o = input_ctrl_r[vpc_pkg::IC_FB_SRC];
    assign aux_sync_source_select_o = input_ctrl_r[vpc_pkg::IC_AUX_SRC];
    assign detector_gain_o = loop_work_r[2:0];
    assign post_scaler_code_o = loop_work_r[5:4];
    assign loop_divider_o = fdiv_work_r;
    assign phase_offset_value_o = phase_ofs_r[5:0];
    assign loop_filter_select_o = phase_ofs_r[vpc_pkg::OFS_FILTER_SEL];
    assign phase_step_resolution_o = phase_res_work_r;
    assign output_enable_o = out_en_r[4:0];
    assign halfclk_invert_o = out_en_r[5];
    assign clk_scale_code_o = out_en_r[7:6];
    assign osc_divider_modulus_o = osc_div_r[6:0];
    assign loop_input_select_o = osc_div_r[vpc_pkg::OSC_LOOP_INPUT];
    assign pll_reset_o = pll_reset_r;
    assign phase_reset_o = phase_reset_r;
    assign lock_indicator_o = lock_ind_r;

    chk_pll_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !pll_load |=> $stable(loop_divider_o) && $stable(detector_gain_o))
        else $error("pll working copy moved without command");
    chk_phase_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !phase_load |=> $stable(phase_step_resolution_o))
        else $error("resolution moved without command");
    chk_pll_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pll_load |=> pll_reset_o && loop_divider_o == {$past(fdiv_high_hold_r[3:0]),
            $past(fdiv_low_hold_r)} ##1 !pll_reset_o)
        else $error("pll command did not load or pulse");
    chk_phase_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        phase_load |=> phase_reset_o && phase_step_resolution_o == $past(phase_res_hold_r))
        else $error("phase command did not load or pulse");
    chk_lock_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !input_ctrl_r[vpc_pkg::IC_SHOW_LOOP] && !input_ctrl_r[vpc_pkg::IC_SHOW_PHASE]
            |=> !lock_indicator_o)
        else $error("lock pin high with both enables clear");
    chk_status_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        line.scl_fall && ptr_r == vpc_pkg::OFF_LOCK_STAT && state_r == vpc_pkg::ST_ACK_OUT
            |=> tx_shift_r == {6'h00, $past(pll_lock_s), $past(phase_lock_s)})
        else $error("status byte wrong");
    chk_addr_miss: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state_r == vpc_pkg::ST_ADDR && byte_done && !addr_hit && !line.stop
            |=> !sda_oe_o && state_r == vpc_pkg::ST_IDLE)
        else $error("answered foreign address");
    chk_input_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_en && ptr_r == vpc_pkg::OFF_INPUT_CTRL
            |=> detector_gate_mode_o == $past(rx_shift_r[vpc_pkg::IC_GATE_MODE]))
        else $error("input control write lost");
endmodule : vpc_regs

// ==== rtl/vpc_pkg.sv ====
package vpc_pkg;
    // serial byte framing
    localparam logic [3:0] BIT_CNT_DONE = 4'h8; // eight bits shifted in
    localparam logic [3:0] BIT_CNT_LAST = 4'h7; // last bit shifted out
    // 7-bit bus address without its select bit: 4ch/4eh write, 4dh/4fh read
    localparam logic [5:0] DEV_ADDR_BASE = 6'h13;
    // register offsets
    localparam logic [7:0] OFF_INPUT_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOOP_CTRL = 8'h01;
    localparam logic [7:0] OFF_FDIV_LOW = 8'h02;
    localparam logic [7:0] OFF_FDIV_HIGH = 8'h03;
    localparam logic [7:0] OFF_PHASE_OFS = 8'h04;
    localparam logic [7:0] OFF_PHASE_CTRL = 8'h05;
    localparam logic [7:0] OFF_OUT_EN = 8'h06;
    localparam logic [7:0] OFF_OSC_DIV = 8'h07;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h08;
    localparam logic [7:0] OFF_CHIP_VER = 8'h10;
    localparam logic [7:0] OFF_CHIP_REV = 8'h11;
    localparam logic [7:0] OFF_LOCK_STAT = 8'h12;
    // reset values
    localparam logic [7:0] RST_INPUT_CTRL = 8'h41;
    localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
    localparam logic [7:0] RST_FDIV_LOW = 8'hff;
    localparam logic [7:0] RST_FDIV_HIGH = 8'h0f;
    localparam logic [7:0] RST_PHASE_OFS = 8'h00;
    localparam logic [1:0] RST_PHASE_RES = 2'h3;
    localparam logic [7:0] RST_OUT_EN = 8'h00;
    localparam logic [7:0] RST_OSC_DIV = 8'h80;
    // writable bits; reserved bits store nothing and read zero
    localparam logic [7:0] MASK_LOOP_CTRL = 8'h37;
    localparam logic [7:0] MASK_FDIV_HIGH = 8'h0f;
    localparam logic [7:0] MASK_PHASE_OFS = 8'hbf;
    // input control bit positions
    localparam int IC_GATE_MODE = 0;
    localparam int IC_GATE_POL = 1;
    localparam int IC_REF_EDGE = 2;
    localparam int IC_FB_EDGE = 3;
    localparam int IC_FB_SRC = 4;
    localparam int IC_AUX_SRC = 5;
    localparam int IC_SHOW_LOOP = 6;
    localparam int IC_SHOW_PHASE = 7;
    // other field positions
    localparam int OFS_FILTER_SEL = 7;
    localparam int OSC_LOOP_INPUT = 7;
    // soft reset command nibbles
    localparam logic [3:0] CMD_PHASE_NIBBLE = 4'ha;
    localparam logic [3:0] CMD_PLL_NIBBLE = 4'h5;
    // metal mask revision field content
    localparam logic [5:0] METAL_REV = 6'h00;
    // serial engine states
    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD, ST_ACK_OUT, ST_ACK_IN} vpc_state_type;
endpackage : vpc_pkg

// ==== rtl/vpc_line_if.sv ====
`timescale 1ns/1ns
interface vpc_line_if;
    logic scl_rise; // serial clock rose
    logic scl_fall; // serial clock fell
    logic start; // start or repeated start seen
    logic stop; // stop seen
    logic sda; // synchronised data level
    modport phy (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : vpc_line_if

// ==== rtl/vpc_pins.sv ====
`timescale 1ns/1ns
module vpc_pins (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // decoded line events
    vpc_line_if.phy line
);
    logic [1:0] pin_in; // bit 0 clock, bit 1 data
    logic [1:0] meta_r; // first stage, read only by sync_r
    logic [1:0] sync_r; // second stage
    logic [1:0] prev_r; // one cycle older, for edges

    assign pin_in = {sda_i, scl_i};

    // two-flop synchroniser plus history, one per pin
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_sync
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    meta_r[g] <= 1'b1;
                    sync_r[g] <= 1'b1;
                    prev_r[g] <= 1'b1;
                end else begin
                    meta_r[g] <= pin_in[g];
                    sync_r[g] <= meta_r[g];
                    prev_r[g] <= sync_r[g];
                end
            end
        end
    endgenerate

    // data moving while the clock stays high frames a transfer
    assign line.scl_rise = sync_r[0] && !prev_r[0];
    assign line.scl_fall = !sync_r[0] && prev_r[0];
    assign line.start = sync_r[0] && prev_r[0] && !sync_r[1] && prev_r[1];
    assign line.stop = sync_r[0] && prev_r[0] && sync_r[1] && !prev_r[1];
    assign line.sda = sync_r[1];
endmodule : vpc_pins

// ==== rtl/vpc_level_sync.sv ====
`timescale 1ns/1ns
module vpc_level_sync (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // asynchronous levels
    input wire logic [2:0] level_i,
    // synchronised levels
    output logic [2:0] level_o
);
    logic [2:0] meta_r; // first stage, read only by the second
    logic [2:0] sync_r; // second stage

    // two flops per level, lock inputs and address select
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_sync
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= level_i[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign level_o = sync_r;
endmodule : vpc_level_sync

// ==== bench/vpc_master.sv ====
`timescale 1ns/1ns
// bus master model; data is open drain with a pull-up, changes while the clock is low
module vpc_master (
    // clock and device pull
    input wire logic clk_sys_i,
    input wire logic sda_oe_i,
    // resolved bus lines
    output logic scl_o,
    output logic sda_o
);
    logic pull = 1'b0; // master pulls data low
    assign sda_o = !(pull | sda_oe_i);
    initial scl_o = 1'b1;
    // set both lines, then hold them a third of a bit
    task drive(input logic c, input logic p);
        scl_o = c;
        pull = p;
        repeat (5) @(negedge clk_sys_i);
    endtask : drive
    // data only moves while the clock is low
    task bit_clk(input logic p, output logic s);
        drive(1'b0, p);
        drive(1'b1, p);
        s = sda_o;
        drive(1'b0, p);
    endtask : bit_clk
    task start;
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
        drive(1'b0, 1'b1);
    endtask : start
    task stop;
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
    endtask : stop
    // msb first; master always leaves the ninth bit released
    task xbyte(input logic [7:0] b, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bit_clk(!b[i], r[i]);
        bit_clk(1'b0, ack);
        ack = !ack;
    endtask : xbyte
endmodule : vpc_master

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic addr_select_i = 1'b0;
    logic pll_locked_i = 1'b1;
    logic phase_locked_i = 1'b0;
    logic scl_i, sda_i, sda_o, sda_oe_o, ack, pll_reset_o, phase_reset_o, lock_indicator_o;
    logic detector_gate_mode_o, detector_gate_polarity_o, reference_edge_select_o;
    logic feedback_edge_select_o, feedback_source_select_o, aux_sync_source_select_o;
    logic loop_filter_select_o, halfclk_invert_o, loop_input_select_o;
    logic [2:0] detector_gain_o;
    logic [1:0] post_scaler_code_o, phase_step_resolution_o, clk_scale_code_o;
    logic [11:0] loop_divider_o;
    logic [5:0] phase_offset_value_o;
    logic [4:0] output_enable_o;
    logic [6:0] osc_divider_modulus_o;
    logic [7:0] rd_data;
    logic [7:0] rst_tab [9] = '{8'h41, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h03, 8'h00, 8'h80, 8'h00};
    int mismatches = 0;
    int num_checks = 0;
    int pulses = 0; // pll pulses in the high nibble, phase pulses in the low
    always #5 clk_sys_i = !clk_sys_i;
    always @(posedge clk_sys_i) pulses <= pulses + 16 * pll_reset_o + phase_reset_o;
    vpc_regs dut_u (.*);
    vpc_master bus_u (.clk_sys_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    // set the pointer, then write one byte or read one back after a repeated start
    task access(input logic [7:0] a, input logic [7:0] d, input bit rd);
        bus_u.start;
        bus_u.xbyte({6'h13, addr_select_i, 1'b0}, rd_data, ack);
        bus_u.xbyte(a, rd_data, ack);
        if (rd) begin
            bus_u.start;
            bus_u.xbyte({6'h13, addr_select_i, 1'b1}, rd_data, ack);
            bus_u.xbyte(8'hff, rd_data, ack);
        end else begin
            bus_u.xbyte(d, rd_data, ack);
        end
        bus_u.stop;
    endtask : access
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        access(a, 8'h00, 1'b1);
        check($sformatf("register %h", a), rd_data, exp);
    endtask : rchk
    task print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        mismatches++;
        print_verdict;
    end
    initial begin
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        foreach (rst_tab[i]) rchk(8'(i), rst_tab[i]);
        check("lock pin at reset", lock_indicator_o, 1'b1);
        check("sda value", sda_o, 1'b0);
        access(8'h01, 8'hff, 1'b0);
        access(8'h02, 8'h34, 1'b0);
        access(8'h03, 8'hf2, 1'b0);
        access(8'h05, 8'h01, 1'b0);
        rchk(8'h01, 8'h37);
        rchk(8'h03, 8'h02);
        // working copies only move on soft reset commands
        check("working", {pulses[7:0], post_scaler_code_o, detector_gain_o, loop_divider_o,
            phase_step_resolution_o}, {8'h00, 2'h0, 3'h0, 12'hfff, 2'h3});
        access(8'h08, 8'h50, 1'b0);
        check("working", {pulses[7:0], post_scaler_code_o, detector_gain_o, loop_divider_o,
            phase_step_resolution_o}, {8'h10, 2'h3, 3'h7, 12'h234, 2'h3});
        access(8'h08, 8'h3a, 1'b0);
        access(8'h08, 8'h33, 1'b0);
        check("working", {pulses[7:0], post_scaler_code_o, detector_gain_o, loop_divider_o,
            phase_step_resolution_o}, {8'h11, 2'h3, 3'h7, 12'h234, 2'h1});
        access(8'h00, 8'hbe, 1'b0);
        access(8'h06, 8'hff, 1'b0);
        access(8'h07, 8'h05, 1'b0);
        access(8'h04, 8'hff, 1'b0);
        rchk(8'h04, 8'hbf);
        check("settings", {aux_sync_source_select_o, feedback_source_select_o,
            feedback_edge_select_o, reference_edge_select_o, detector_gate_polarity_o,
            detector_gate_mode_o, clk_scale_code_o, halfclk_invert_o, output_enable_o,
            loop_input_select_o, osc_divider_modulus_o, loop_filter_select_o,
            phase_offset_value_o}, {6'h3e, 8'hff, 8'h05, 7'h7f});
        check("lock pin", lock_indicator_o, 1'b0);
        rchk(8'h12, 8'h02);
        phase_locked_i = 1'b1;
        repeat (5) @(negedge clk_sys_i);
        check("lock pin", lock_indicator_o, 1'b1);
        rchk(8'h12, 8'h03);
        // both status enables clear: pin low although both loops are locked
        access(8'h00, 8'h3e, 1'b0);
        check("lock pin disabled", lock_indicator_o, 1'b0);
        access(8'h10, 8'h00, 1'b0);
        rchk(8'h10, 8'h5a);
        rchk(8'h11, 8'h0c);
        addr_select_i = 1'b1;
        rchk(8'h07, 8'h05);
        bus_u.start;
        bus_u.xbyte(8'h4c, rd_data, ack);
        bus_u.stop;
        check("foreign address ack", ack, 1'b0);
        print_verdict;
    end
endmodule : tb_top
